//--- core/rsf_pkg.sv
// rsf_pkg: shared constants and types for the reset source and flag sequencer
package rsf_pkg;
   // ------------------------------------------------------------
   // timing
   // ------------------------------------------------------------
   localparam int          CLK_PERIOD_PS    = 8000;        // 125 mhz system clock
   localparam int          POWER_ON_DELAY_US = 16700;      // typical power-on hold-off, 16.7 ms
   // cycles of power-on delay, rounded down as a typical figure;
   // both sides brought to ns first so the product stays inside int range
   localparam int          POWER_ON_CYCLES  = (POWER_ON_DELAY_US * 1000) / (CLK_PERIOD_PS / 1000);
   localparam logic [4:0]  SETTLE_FAST_CYC  = 5'h0010;     // wake settle, fast osc, 15..16
   localparam logic [4:0]  SETTLE_SLOW_CYC  = 5'h0002;     // wake settle, slow osc, 1..2
   localparam logic [4:0]  SETTLE_ZERO      = 5'h0000;     // settle counter idle value
   // ------------------------------------------------------------
   // reset values
   // ------------------------------------------------------------
   localparam logic [12:0] PC_RESET         = 13'h0000;    // program counter after reset
   localparam logic [3:0]  SP_RESET         = 4'h0;        // stack pointer after halt watchdog wake
   localparam logic [3:0]  SP_TOP           = 4'hF;        // stack pointer top of stack
   localparam logic [7:0]  PORT_DIR_INPUT   = 8'hFF;       // 1 = pin is input
   localparam logic [7:0]  IRQ_EN_OFF       = 8'h00;       // all interrupt enables off
   // ------------------------------------------------------------
   // sequencer states
   // ------------------------------------------------------------
   typedef enum logic [2:0] {
      RSF_POR_HOLD,     // full reset, power-on delay running
      RSF_RUN,          // normal or slow run
      RSF_HALTED,       // sleep or idle
      RSF_SETTLE        // wake settle after watchdog or wake request in halt
   } rsf_state_t;
endpackage

//--- core/rsf_delay_cnt.sv
// rsf_delay_cnt: loadable down counter used for power-on delay
`timescale 1ns/1ps
module rsf_delay_cnt #(
   parameter int          WIDTH = 24
) (
   input  wire logic               sys_clk,
   input  wire logic               sys_rst,
   input  wire logic               load,      // pulse: restart count
   input  wire logic [WIDTH-1:0]   load_val,  // cycles to count
   output logic                    busy       // high while counting
);
   // ------------------------------------------------------------
   // counter
   // ------------------------------------------------------------
   logic [WIDTH-1:0] cnt_ff;                  // remaining cycles

   // count down, load wins over counting
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         cnt_ff <= '0;
      end else if (load) begin
         cnt_ff <= load_val;
      end else if (cnt_ff != '0) begin
         cnt_ff <= cnt_ff - 1'b1;
      end
   end

   assign busy = (cnt_ff != '0);
endmodule

//--- core/rsf_wdog.sv
// rsf_wdog: watchdog counter on slow-oscillator ticks with overflow pulse
`timescale 1ns/1ps
module rsf_wdog #(
   parameter int          WIDTH = 18
) (
   input  wire logic               sys_clk,
   input  wire logic               sys_rst,
   input  wire logic               slow_tick,  // one pulse per slow osc period
   input  wire logic               clear,      // clear instruction, halt or reset
   output logic                    overflow    // one-cycle pulse on wrap
);
   // ------------------------------------------------------------
   // counter
   // ------------------------------------------------------------
   logic [WIDTH-1:0] cnt_ff;                   // running count
   logic             ovf_ff;                   // registered overflow pulse

   // counts from the slow tick only, so it keeps running in halt
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         cnt_ff <= '0;
         ovf_ff <= 1'b0;
      end else if (clear) begin
         cnt_ff <= '0;
         ovf_ff <= 1'b0;
      end else begin
         ovf_ff <= slow_tick && (&cnt_ff);
         if (slow_tick) begin
            cnt_ff <= cnt_ff + 1'b1;
         end
      end
   end

   assign overflow = ovf_ff;
endmodule

//--- core/rsf_seq.sv
// rsf_seq: reset source sequencer with timeout and powerdown flag logic
//
// Functional notes
// - run watchdog timeout: full reset plus timeout set
// - hold execution for power-on delay after full reset
// - halt watchdog: clear only pc, sp; set timeout
// - fast osc wake settle lasts 15 to 16 cycles
// - slow osc wake settle lasts 1 to 2 cycles
// - flags updated by halt entry and watchdog
// - power-on clears flags; halt watchdog sets both
// - supply drop reset keeps both flags
// - run watchdog sets timeout, keeps powerdown
// - power-on disables every interrupt source
// - power-on clears watchdog, counting starts at once
// - power-on stops timer, ports become inputs
// - power-on: pc zero, sp at stack top
// - watchdog timeout on counter overflow, slow clock
`timescale 1ns/1ps
module rsf_seq #(
   parameter int          POR_CYCLES = rsf_pkg::POWER_ON_CYCLES,  // power-on delay in cycles
   parameter int          WDOG_WIDTH = 18,                        // watchdog counter width
   parameter int          DLY_WIDTH  = 24                         // power-on counter width
) (
   input  wire logic            sys_clk,            // 125 mhz system clock
   input  wire logic            sys_rst,            // power-on reset, async high
   input  wire logic            supply_drop_reset,  // level: supply monitor trips
   input  wire logic            slow_tick,          // pulse: slow osc period
   input  wire logic            clr_watchdog,       // pulse: clear watchdog instruction
   input  wire logic            halt_req,           // pulse: enter sleep or idle
   input  wire logic            wake_req,           // pulse: interrupt wake from halt
   input  wire logic            clk_src_slow,       // level: system clock is slow osc
   output logic                 timeout_flag,       // status timeout flag
   output logic                 powerdown_flag,     // status powerdown flag
   output logic                 cpu_run,            // high when program may execute
   output logic                 core_reset,         // full reset of core registers
   output logic                 pc_sp_clear,        // pulse: clear pc and sp only
   output logic [12:0]          pc_init,            // program counter load value
   output logic [3:0]           sp_init,            // stack pointer load value
   output logic [7:0]           irq_enable,         // interrupt enable mask
   output logic                 timer_on,           // timer and event counter enable
   output logic [7:0]           port_dir            // 1 = pin is input
);
   // ------------------------------------------------------------
   // declarations
   // ------------------------------------------------------------
   rsf_pkg::rsf_state_t  state_ff;            // sequencer state
   rsf_pkg::rsf_state_t  nxt_state;           // next state
   logic                 tout_ff;             // timeout flag
   logic                 pdn_ff;              // powerdown flag
   logic                 boot_ff;             // first cycle after power-on reset
   logic                 run_ff;              // execution allowed
   logic                 core_rst_ff;         // full reset output
   logic                 pcsp_ff;             // pc/sp clear pulse
   logic [12:0]          pc_ff;               // pc load value
   logic [3:0]           sp_ff;               // sp load value
   logic [7:0]           irq_ff;              // interrupt enables
   logic                 tmr_ff;              // timer enable
   logic [7:0]           dir_ff;              // port directions
   logic [4:0]           settle_ff;           // wake settle count
   logic                 drop_ff;             // supply drop delayed, for edge
   logic                 wdog_ovf;            // watchdog overflow pulse
   logic                 wdog_clear;          // watchdog clear request
   logic                 dly_load;            // start power-on delay
   logic                 dly_busy;            // power-on delay running
   logic                 drop_rise;           // supply drop event
   logic                 full_reset;          // any full reset event
   logic                 run_wdog;            // watchdog in run
   logic                 halt_wdog;           // watchdog in halt

   // settle length chosen by clock source
   function automatic logic [4:0] settle_len(input logic slow);
      settle_len = slow ? rsf_pkg::SETTLE_SLOW_CYC : rsf_pkg::SETTLE_FAST_CYC;
   endfunction

   // ------------------------------------------------------------
   // event decode
   // ------------------------------------------------------------
   // edge on the supply monitor; it is already synchronous
   // a level held high resets once; the monitor must fall and trip again
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         drop_ff <= 1'b0;
      end else begin
         drop_ff <= supply_drop_reset;
      end
   end

   // power-on marker: one cycle after release it starts the power-on
   // delay, so a plain power-on holds execution off like any full reset
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         boot_ff <= 1'b1;
      end else begin
         boot_ff <= 1'b0;
      end
   end

   assign drop_rise  = supply_drop_reset && !drop_ff;
   assign run_wdog   = wdog_ovf && (state_ff == rsf_pkg::RSF_RUN);
   assign halt_wdog  = wdog_ovf && (state_ff == rsf_pkg::RSF_HALTED);
   // run timeout is a full reset
   assign full_reset = drop_rise || run_wdog;
   // delay starts on power-on and every full reset
   assign dly_load   = full_reset || boot_ff;
   // cleared by full reset, halt entry and instruction
   assign wdog_clear = full_reset || clr_watchdog
                       || (halt_req && state_ff == rsf_pkg::RSF_RUN);

   // ------------------------------------------------------------
   // sub-blocks
   // ------------------------------------------------------------
   // the watchdog sees only slow ticks, so its period follows the slow
   // oscillator and not the system clock, and it keeps running in halt
   rsf_wdog #(
      .WIDTH     (WDOG_WIDTH)
   ) u_wdog (
      .sys_clk   (sys_clk),
      .sys_rst   (sys_rst),
      .slow_tick (slow_tick),
      .clear     (wdog_clear),
      .overflow  (wdog_ovf)
   );

   rsf_delay_cnt #(
      .WIDTH     (DLY_WIDTH)
   ) u_por_dly (
      .sys_clk   (sys_clk),
      .sys_rst   (sys_rst),
      .load      (dly_load),
      .load_val  (DLY_WIDTH'(POR_CYCLES)),
      .busy      (dly_busy)
   );

   // ------------------------------------------------------------
   // state machine
   // ------------------------------------------------------------
   // next state; full reset overrides everything
   always_comb begin
      nxt_state = state_ff;
      case (state_ff)
         rsf_pkg::RSF_POR_HOLD: begin
            // leave only once the delay expired
            if (!dly_busy && !dly_load) begin
               nxt_state = rsf_pkg::RSF_RUN;
            end
         end
         rsf_pkg::RSF_RUN: begin
            if (halt_req) begin
               nxt_state = rsf_pkg::RSF_HALTED;
            end
         end
         rsf_pkg::RSF_HALTED: begin
            if (halt_wdog || wake_req) begin
               nxt_state = rsf_pkg::RSF_SETTLE;
            end
         end
         rsf_pkg::RSF_SETTLE: begin
            // limitation: an overflow during settle is dropped; the count
            // has wrapped, so the next one comes a full period later
            if (settle_ff == rsf_pkg::SETTLE_ZERO) begin
               nxt_state = rsf_pkg::RSF_RUN;
            end
         end
         default: begin
            nxt_state = rsf_pkg::RSF_POR_HOLD;
         end
      endcase
      if (full_reset) begin
         nxt_state = rsf_pkg::RSF_POR_HOLD;
      end
   end

   // state register; reset starts the delay via first-cycle load
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         state_ff <= rsf_pkg::RSF_POR_HOLD;
      end else begin
         state_ff <= nxt_state;
      end
   end

   // ------------------------------------------------------------
   // wake settle counter
   // ------------------------------------------------------------
   // loaded one short of the length: the load cycle itself counts,
   // so settle spans settle_len cycles before run resumes
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         settle_ff <= rsf_pkg::SETTLE_ZERO;
      end else if (state_ff == rsf_pkg::RSF_HALTED && (halt_wdog || wake_req)) begin
         settle_ff <= settle_len(clk_src_slow) - 5'h0001;
      end else if (settle_ff != rsf_pkg::SETTLE_ZERO) begin
         settle_ff <= settle_ff - 5'h0001;
      end
   end

   // ------------------------------------------------------------
   // status flags
   // ------------------------------------------------------------
   // power-on clears both flags
   // priority follows event weight: halt watchdog, run watchdog, then
   // supply drop; any set beats a halt-entry or clear update in the
   // same cycle, so a timeout is never lost to software
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         tout_ff <= 1'b0;
         pdn_ff  <= 1'b0;
      end else if (halt_wdog) begin
         tout_ff <= 1'b1;
         pdn_ff  <= 1'b1;
      end else if (run_wdog) begin
         tout_ff <= 1'b1;
      end else if (drop_rise) begin
         tout_ff <= tout_ff;
      end else if (halt_req && state_ff == rsf_pkg::RSF_RUN) begin
         // halt entry marks powerdown, clears timeout
         tout_ff <= 1'b0;
         pdn_ff  <= 1'b1;
      end else if (clr_watchdog && state_ff == rsf_pkg::RSF_RUN) begin
         tout_ff <= 1'b0;
         pdn_ff  <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // core control outputs
   // ------------------------------------------------------------
   // full reset held for the whole delay; execution after it
   // both decoded from the next state, so they move on the same edge
   // as the state itself and still leave straight from flip-flops
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         core_rst_ff <= 1'b1;
         run_ff      <= 1'b0;
      end else begin
         core_rst_ff <= (nxt_state == rsf_pkg::RSF_POR_HOLD);
         run_ff      <= (nxt_state == rsf_pkg::RSF_RUN);
      end
   end

   // pc/sp clear pulse and load values
   // sp stays at zero after a halt watchdog wake until the next full reset
   // restores the stack top; software must not rely on it otherwise
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         pcsp_ff <= 1'b0;
         pc_ff   <= rsf_pkg::PC_RESET;
         sp_ff   <= rsf_pkg::SP_TOP;
      end else if (full_reset) begin
         pcsp_ff <= 1'b0;
         pc_ff   <= rsf_pkg::PC_RESET;
         sp_ff   <= rsf_pkg::SP_TOP;
      end else if (halt_wdog) begin
         pcsp_ff <= 1'b1;
         pc_ff   <= rsf_pkg::PC_RESET;
         sp_ff   <= rsf_pkg::SP_RESET;
      end else begin
         pcsp_ff <= 1'b0;
      end
   end

   // peripheral state after full reset; untouched by halt wake
   // limitation: only the reset pattern is forced here; later software
   // writes belong to the peripheral registers downstream
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         irq_ff <= rsf_pkg::IRQ_EN_OFF;
         tmr_ff <= 1'b0;
         dir_ff <= rsf_pkg::PORT_DIR_INPUT;
      end else if (full_reset) begin
         irq_ff <= rsf_pkg::IRQ_EN_OFF;
         tmr_ff <= 1'b0;
         dir_ff <= rsf_pkg::PORT_DIR_INPUT;
      end
   end

   assign timeout_flag   = tout_ff;
   assign powerdown_flag = pdn_ff;
   assign cpu_run        = run_ff;
   assign core_reset     = core_rst_ff;
   assign pc_sp_clear    = pcsp_ff;
   assign pc_init        = pc_ff;
   assign sp_init        = sp_ff;
   assign irq_enable     = irq_ff;
   assign timer_on       = tmr_ff;
   assign port_dir       = dir_ff;
endmodule

//--- testbench/rsf_seq_asserts.sv
// rsf_seq_asserts: port-level checks on the reset sequencer, bound into rsf_seq
`timescale 1ns/1ps
module rsf_seq_asserts (
   input wire logic        sys_clk,
   input wire logic        sys_rst,
   input wire logic        supply_drop_reset,
   input wire logic        slow_tick,
   input wire logic        clr_watchdog,
   input wire logic        halt_req,
   input wire logic        wake_req,
   input wire logic        clk_src_slow,
   input wire logic        timeout_flag,
   input wire logic        powerdown_flag,
   input wire logic        cpu_run,
   input wire logic        core_reset,
   input wire logic        pc_sp_clear,
   input wire logic [12:0] pc_init,
   input wire logic [3:0]  sp_init,
   input wire logic [7:0]  irq_enable,
   input wire logic        timer_on,
   input wire logic [7:0]  port_dir
);
   // one clock domain, power-on reset silences every check
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (sys_rst);
   // ----------------------------------------
   // full reset state
   // ----------------------------------------
   por_state_a: assert property (
      core_reset |-> irq_enable == 8'h00 && !timer_on && port_dir == 8'hFF)
      else $error("peripherals left active during full reset");
   stack_top_a: assert property (
      core_reset |-> sp_init == 4'hF && pc_init == 13'h0000)
      else $error("pc or sp wrong during full reset");
   hold_off_a: assert property (
      $rose(core_reset) |-> !cpu_run ##1 (core_reset && !cpu_run)[*8])
      else $error("execution not held off after full reset");
   drop_start_a: assert property (
      $rose(supply_drop_reset) |-> ##[1:3] core_reset)
      else $error("supply drop gave no full reset");
   drop_flags_a: assert property (
      $rose(supply_drop_reset) |=> ($stable(timeout_flag) && $stable(powerdown_flag))[*2])
      else $error("supply drop changed a status flag");
   // ----------------------------------------
   // watchdog while halted
   // ----------------------------------------
   pulse_len_a: assert property (
      pc_sp_clear |=> !pc_sp_clear)
      else $error("pc and sp clear pulse too long");
   halt_flags_a: assert property (
      pc_sp_clear |-> timeout_flag && powerdown_flag && sp_init == 4'h0 && !core_reset)
      else $error("halt watchdog left wrong flags or state");
   fast_settle_a: assert property (
      pc_sp_clear && !clk_src_slow |=> !cpu_run[*8] ##[7:10] cpu_run)
      else $error("fast oscillator settle time wrong");
   slow_settle_a: assert property (
      pc_sp_clear && clk_src_slow |-> ##[1:4] cpu_run)
      else $error("slow oscillator settle time wrong");
   pwrdn_cause_a: assert property (
      $rose(powerdown_flag) |-> $past(halt_req) || pc_sp_clear)
      else $error("powerdown flag set without halt or watchdog");
endmodule
bind rsf_seq rsf_seq_asserts rsf_seq_asserts_i (
   .sys_clk(sys_clk), .sys_rst(sys_rst), .supply_drop_reset(supply_drop_reset),
   .slow_tick(slow_tick), .clr_watchdog(clr_watchdog), .halt_req(halt_req),
   .wake_req(wake_req), .clk_src_slow(clk_src_slow), .timeout_flag(timeout_flag),
   .powerdown_flag(powerdown_flag), .cpu_run(cpu_run), .core_reset(core_reset),
   .pc_sp_clear(pc_sp_clear), .pc_init(pc_init), .sp_init(sp_init),
   .irq_enable(irq_enable), .timer_on(timer_on), .port_dir(port_dir));

//--- testbench/test_rsf_seq.sv
// test_rsf_seq: self-checking bench for the reset source and flag sequencer
`timescale 1ns/1ps
module test_rsf_seq;
   // ----------------------------------------
   // setup
   // ----------------------------------------
   localparam int POR = 20;   // shortened power-on delay keeps the run short
   localparam int WDW = 4;    // shortened watchdog, wraps after 16 ticks
   logic        sys_clk, sys_rst, supply_drop_reset, slow_tick;
   logic        clr_watchdog, halt_req, wake_req, clk_src_slow;
   logic        timeout_flag, powerdown_flag, cpu_run, core_reset, pc_sp_clear, timer_on;
   logic [12:0] pc_init;
   logic [3:0]  sp_init;
   logic [7:0]  irq_enable, port_dir;
   int          n_fail = 0;      // mismatches
   int          n_compared = 0;  // comparisons
   int          seed = 28;       // fixed seed, repeatable run
   int          n, r, s;
   rsf_seq #(.POR_CYCLES(POR), .WDOG_WIDTH(WDW)) rsf_seq_i (
      .sys_clk(sys_clk), .sys_rst(sys_rst), .supply_drop_reset(supply_drop_reset),
      .slow_tick(slow_tick), .clr_watchdog(clr_watchdog), .halt_req(halt_req),
      .wake_req(wake_req), .clk_src_slow(clk_src_slow), .timeout_flag(timeout_flag),
      .powerdown_flag(powerdown_flag), .cpu_run(cpu_run), .core_reset(core_reset),
      .pc_sp_clear(pc_sp_clear), .pc_init(pc_init), .sp_init(sp_init),
      .irq_enable(irq_enable), .timer_on(timer_on), .port_dir(port_dir));
   // 125 mhz clock
   initial begin
      sys_clk = 1'b0;
      forever #4 sys_clk = ~sys_clk;
   end
   // ----------------------------------------
   // helpers
   // ----------------------------------------
   // inputs always move 1 ns after the rising edge, away from sampling
   task step(int k);
      repeat (k) begin
         @(posedge sys_clk);
         #1;
      end
   endtask
   task check(logic ok, string m);
      n_compared++;
      if (ok !== 1'b1) begin
         n_fail++;
         $display("MISMATCH t=%0t %s", $time, m);
      end
   endtask
   // 0 clear instruction, 1 halt, 2 wake; one-cycle strobes
   task strobe(int w);
      case (w)
         0: clr_watchdog = 1'b1;
         1: halt_req = 1'b1;
         default: wake_req = 1'b1;
      endcase
      step(1);
      clr_watchdog = 1'b0;
      halt_req = 1'b0;
      wake_req = 1'b0;
      step(1);
   endtask
   // slow oscillator ticks, one idle cycle between them
   task ticks(int k);
      repeat (k) begin
         slow_tick = 1'b1;
         step(1);
         slow_tick = 1'b0;
         step(1);
      end
   endtask
   // bounded wait: 0 cpu_run, 1 core_reset, 2 pc_sp_clear; cnt = cycles waited
   task wait_sig(int sel, int lim, output int cnt);
      logic v;
      cnt = 0;
      v = (sel == 0) ? cpu_run : (sel == 1) ? core_reset : pc_sp_clear;
      while (v !== 1'b1) begin
         if (cnt >= lim) begin
            n_fail++;
            $display("MISMATCH t=%0t wait for %0d expired", $time, sel);
            stop_test();
         end
         cnt++;
         step(1);
         v = (sel == 0) ? cpu_run : (sel == 1) ? core_reset : pc_sp_clear;
      end
   endtask
   // expected settle length from the oscillator choice
   function automatic int settle_of(logic slow);
      return slow ? int'(rsf_pkg::SETTLE_SLOW_CYC) : int'(rsf_pkg::SETTLE_FAST_CYC);
   endfunction
   task stop_test();
      $display("compared %0d mismatches %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial begin
      sys_rst = 1'b1;
      supply_drop_reset = 1'b0;
      slow_tick = 1'b0;
      clr_watchdog = 1'b0;
      halt_req = 1'b0;
      wake_req = 1'b0;
      clk_src_slow = 1'b0;
      step(6);
      sys_rst = 1'b0;
      // power-on state
      check(timeout_flag === 1'b0 && powerdown_flag === 1'b0, "flags after power-on");
      check(irq_enable === rsf_pkg::IRQ_EN_OFF, "interrupts enabled");
      check(timer_on === 1'b0 && port_dir === rsf_pkg::PORT_DIR_INPUT, "timer or ports");
      check(pc_init === rsf_pkg::PC_RESET && sp_init === rsf_pkg::SP_TOP, "pc or sp");
      wait_sig(0, POR + 6, n);
      check(n >= POR && n <= POR + 3, "power-on hold length");
      $display("test power-on done");
      // watchdog starts from zero: one tick short of a wrap is harmless
      ticks((1 << WDW) - 1);
      check(cpu_run === 1'b1 && core_reset === 1'b0, "watchdog wrapped early");
      ticks(1);
      wait_sig(1, 4, n);
      check(timeout_flag === 1'b1 && powerdown_flag === 1'b0, "run watchdog flags");
      wait_sig(0, POR + 6, n);
      check(n >= POR - 1 && n <= POR + 3, "power-on delay length");
      $display("test run watchdog done");
      // random partial count, then a clear restarts the full span
      r = $random(seed);
      ticks(1 + ($unsigned(r) % ((1 << WDW) - 1)));
      strobe(0);
      ticks((1 << WDW) - 1);
      check(cpu_run === 1'b1 && core_reset === 1'b0, "clear did not restart");
      $display("test watchdog clear done");
      // halt then wake, then a supply drop must keep both flags
      strobe(0);
      strobe(1);
      check(powerdown_flag === 1'b1 && timeout_flag === 1'b0, "halt flags");
      check(cpu_run === 1'b0, "running while halted");
      strobe(2);
      wait_sig(0, 20, n);
      supply_drop_reset = 1'b1;
      wait_sig(1, 3, n);
      check(timeout_flag === 1'b0 && powerdown_flag === 1'b1, "drop changed flags");
      supply_drop_reset = 1'b0;
      wait_sig(0, POR + 6, n);
      $display("test supply drop done");
      // watchdog wrap while halted, both oscillators in random order
      r = $random(seed);
      for (int i = 0; i < 2; i++) begin
         clk_src_slow = r[0] ^ i[0];
         strobe(0);
         strobe(1);
         ticks((1 << WDW) - 1);
         slow_tick = 1'b1;
         step(1);
         slow_tick = 1'b0;
         wait_sig(2, 6, n);
         check(timeout_flag === 1'b1 && powerdown_flag === 1'b1, "halt wrap flags");
         check(sp_init === rsf_pkg::SP_RESET && core_reset === 1'b0, "halt wrap state");
         s = settle_of(clk_src_slow);
         wait_sig(0, 30, n);
         check(n >= s - 1 && n <= s + 2, "wake settle length");
      end
      $display("test halt watchdog done");
      // power-on again in mid-run: both flags stand at 1 and must clear
      sys_rst = 1'b1;
      step(2);
      sys_rst = 1'b0;
      check(timeout_flag === 1'b0 && powerdown_flag === 1'b0, "flags after reset");
      check(sp_init === rsf_pkg::SP_TOP && core_reset === 1'b1, "state after reset");
      wait_sig(0, POR + 6, n);
      check(n >= POR && n <= POR + 3, "hold length after reset");
      $display("test second power-on done");
      stop_test();
   end
endmodule
